// ==== rtl/index_unit_map.vh ====
/*
 * index unit constants: field positions, widths, limits and op codes.
 * assumes inclusion by bare name from the index unit design files.
 */
`ifndef INDEX_UNIT_MAP_VH
`define INDEX_UNIT_MAP_VH

// address and word widths
`define ADDR_W 24
`define WORD_W 32
// instruction fields, msb numbering 0..31 mapped to verilog [31:0]
// tag is hex digit 3, base digit 4, displacement digits 5 to 7
`define TAG_HI 19
`define TAG_LO 16
`define BASE_HI 15
`define BASE_LO 12
`define DISP_HI 11
`define DISP_LO 0
// branch tag: indirect flag position only
`define TAG_INDIR_BIT 3
// highest address that means a register when not branching
`define REG_LIMIT 24'h00002f
// indirect word fields
`define IW_ZERO_HI 31
`define IW_ZERO_LO 28
`define IW_MORE_BIT 27
`define IW_IDX_HI 26
`define IW_IDX_LO 24
// operation codes of the unit
`define OP_BRANCH 2'h0
`define OP_IMM_HALF 2'h1
`define OP_IMM_ARITH 2'h2
`define OP_IMM_LOGIC 2'h3

`endif

// ==== rtl/adder24.v ====
/*
 * 24-bit three-input wrapping adder used for every index sum.
 * assumes purely combinational use by the index unit.
 */
`timescale 1ns/1ps
`include "index_unit_map.vh"

module adder24 #(
  parameter W = 24
) (
  input wire [W-1:0] a_i,
  input wire [W-1:0] b_i,
  input wire [W-1:0] c_i,
  output wire [W-1:0] sum_o
);
  // carry out of the top bit is dropped on purpose: addresses wrap
  assign sum_o = a_i + b_i + c_i;
endmodule

// ==== rtl/reg_select.v ====
/*
 * selects one register value by number; number zero yields zero.
 * assumes the register file is presented as a flat bus of n words.
 */
`timescale 1ns/1ps

module reg_select #(
  parameter N = 16,
  parameter SW = 4,
  parameter W = 32
) (
  input wire [N*W-1:0] regs_i,
  input wire [SW-1:0] sel_i,
  output reg [W-1:0] value_o
);
  integer k;

  // zero selector means no register, so it reads as zero
  always @* begin
    value_o = {W{1'b0}};
    for (k = 1; k < N; k = k + 1) begin
      if (sel_i == k[SW-1:0]) begin
        value_o = regs_i[k*W +: W];
      end
    end
  end
endmodule

// ==== rtl/branch_and_immediate_index_unit.v ====
/*
 * index unit datapath: branch target and immediate operand forming.
 * one request at a time; the unit answers either at once (immediates
 * and direct branches) or after an indirect chain through memory.
 * instruction fields: tag in bits 19:16, base selector in 15:12 and
 * displacement in 11:0, so base and displacement together are the
 * right half that immediates use as their operand.
 * index file has eight words, base file sixteen; word zero of each is
 * never read, since a zero selector means no register.
 * all sums go through 24-bit adders; carries out of the top are lost,
 * so addresses and modified immediates wrap.
 * reset clears every output and leaves the unit idle.
 * no chain depth limit: a chain that never ends keeps the unit busy.
 * assumes the pipeline holds req_i and op_i until done_o, and drops
 * req_i for at least one cycle before the next request.
 * assumes memory answers an indirect fetch with a one-cycle mem_ack_i
 * while mem_req_o is high, with the word on mem_data_i in that cycle.
 * assumes the program counter input names the instruction now at the
 * index addition stage and stays steady while a request is held.
 */
// Notes on behaviour
// - base zero: signed displacement plus counter, plus index for tag 1-7.
// - base 1-F: unsigned displacement plus base register, plus index tag 1-7.
// - tag 8 and up is indirect; tags 9-F add index tag minus eight.
// - counter forms use signed 12-bit displacement; base forms unsigned 12-bit.
// - one target computation serves every test-and-branch instruction.
// - indirect words decode like operand indirection; low addresses still memory.
// - targets at or below 2F go to memory; never to registers.
// - halfword immediate is base and displacement fields, signed two's complement.
// - nonzero index adds right half of index register as signed value.
// - singleword arithmetic immediate sign-extends the right half.
// - arithmetic indexing adds index bits 8-31 unextended; only the sum is extended.
// - sign extension happens locally; register file contents stay untouched.
// - 24-bit adder result is sign-extended from bit 8 to 32 bits.
// - logical immediate zero-fills left half, adds low 24 index bits.
// - the 24-bit counter feeds relative branch computation.
// - indirect word: zero code, further flag, index selector, address.
// - nonzero top code in an indirect chain raises illegal operation.
`timescale 1ns/1ps
`include "index_unit_map.vh"

module branch_and_immediate_index_unit #(
  parameter AW = 24,
  parameter WW = 32
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire req_i,
  input wire [1:0] op_i,
  input wire [WW-1:0] instr_i,
  input wire [AW-1:0] instruction_address_counter_i,
  input wire [8*WW-1:0] index_regs_i,
  input wire [16*WW-1:0] base_regs_i,
  input wire [WW-1:0] mem_data_i,
  input wire mem_ack_i,
  output reg mem_req_o,
  output reg [AW-1:0] mem_addr_o,
  output reg [AW-1:0] branch_target_o,
  output reg [WW-1:0] immediate_value_o,
  output reg done_o,
  output reg illegal_op_o,
  output reg busy_o
);
  // instruction fields
  wire [3:0] tag = instr_i[`TAG_HI:`TAG_LO];
  wire [3:0] base_sel = instr_i[`BASE_HI:`BASE_LO];
  wire [11:0] disp = instr_i[`DISP_HI:`DISP_LO];
  wire [15:0] mn = {base_sel, disp};
  wire [2:0] idx_sel = tag[2:0];

  // register selections; index file has 8 slots, slot zero unused
  wire [WW-1:0] base_val;
  wire [WW-1:0] idx_val;
  wire [WW-1:0] chain_idx_val;
  wire [2:0] chain_sel;

  reg_select #(.N(16), .SW(4), .W(WW)) u_base_sel (
    .regs_i(base_regs_i),
    .sel_i(base_sel),
    .value_o(base_val)
  );

  reg_select #(.N(8), .SW(3), .W(WW)) u_idx_sel (
    .regs_i(index_regs_i),
    .sel_i(idx_sel),
    .value_o(idx_val)
  );

  reg_select #(.N(8), .SW(3), .W(WW)) u_chain_sel (
    .regs_i(index_regs_i),
    .sel_i(chain_sel),
    .value_o(chain_idx_val)
  );

  // displacement forms
  wire [AW-1:0] disp_signed = {{12{disp[11]}}, disp};
  wire [AW-1:0] disp_unsigned = {12'h000, disp};

  // branch operands: one form shared by all test-and-branch ops
  reg [AW-1:0] br_a;
  reg [AW-1:0] br_b;
  reg [AW-1:0] br_c;
  always @* begin
    if (base_sel == 4'h0) begin
      br_a = disp_signed;
      br_b = instruction_address_counter_i;
    end else begin
      br_a = disp_unsigned;
      br_b = base_val[AW-1:0];
    end
    // tag 1-7 direct index, 9-F index tag minus eight; low three bits
    br_c = (idx_sel != 3'h0) ? idx_val[AW-1:0] : {AW{1'b0}};
  end

  wire [AW-1:0] br_sum;
  adder24 #(.W(AW)) u_br_add (
    .a_i(br_a),
    .b_i(br_b),
    .c_i(br_c),
    .sum_o(br_sum)
  );

  // immediate operands and index addends
  wire [AW-1:0] half_imm = {{8{mn[15]}}, mn};
  wire [AW-1:0] half_idx = {{8{idx_val[15]}}, idx_val[15:0]};
  // index bit 8 (msb numbering) is verilog bit 23; local copy only
  wire [AW-1:0] arith_idx = idx_val[AW-1:0];
  wire [AW-1:0] logic_imm = {8'h00, mn};

  reg [AW-1:0] im_b;
  reg [AW-1:0] im_a;
  always @* begin
    im_a = (op_i == `OP_IMM_LOGIC) ? logic_imm : half_imm;
    if (idx_sel == 3'h0) begin
      im_b = {AW{1'b0}};
    end else if (op_i == `OP_IMM_HALF) begin
      im_b = half_idx;
    end else begin
      im_b = arith_idx;
    end
  end

  wire [AW-1:0] im_sum;
  adder24 #(.W(AW)) u_im_add (
    .a_i(im_a),
    .b_i(im_b),
    .c_i({AW{1'b0}}),
    .sum_o(im_sum)
  );

  // final operand width handling per immediate kind
  reg [WW-1:0] im_word;
  always @* begin
    case (op_i)
      `OP_IMM_HALF: im_word = {16'h0000, im_sum[15:0]};
      `OP_IMM_ARITH: im_word = {{8{im_sum[AW-1]}}, im_sum};
      `OP_IMM_LOGIC: im_word = {8'h00, im_sum};
      default: im_word = {WW{1'b0}};
    endcase
  end

  // indirect chain: decoded word fields
  wire [3:0] iw_zero = mem_data_i[`IW_ZERO_HI:`IW_ZERO_LO];
  wire iw_more = mem_data_i[`IW_MORE_BIT];
  wire [2:0] iw_idx = mem_data_i[`IW_IDX_HI:`IW_IDX_LO];
  wire [AW-1:0] iw_addr = mem_data_i[AW-1:0];

  // each level's own index added to its address
  wire [AW-1:0] chain_sum;
  adder24 #(.W(AW)) u_chain_add (
    .a_i(iw_addr),
    .b_i((iw_idx != 3'h0) ? chain_idx_val[AW-1:0] : {AW{1'b0}}),
    .c_i({AW{1'b0}}),
    .sum_o(chain_sum)
  );

  // chain select follows the word on the data input: the word is only
  // valid in the ack cycle, so the index is picked combinationally
  assign chain_sel = iw_idx;

  // control states, binary coded; the unused code falls back to idle
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_FETCH = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;

  // control sequence: present values and their next values
  reg [1:0] state_reg;
  reg [1:0] state_next;
  // pending flag remembers a done whose request is still high
  reg done_pend_reg;
  reg done_pend_next;
  reg mem_req_next;
  reg [AW-1:0] mem_addr_next;
  reg [AW-1:0] target_next;
  reg [WW-1:0] imm_next;
  reg done_next;
  reg illegal_next;
  reg busy_next;

  // next values; outputs hold unless a step below changes them
  always @* begin
    state_next = state_reg;
    done_pend_next = done_pend_reg;
    mem_req_next = mem_req_o;
    mem_addr_next = mem_addr_o;
    target_next = branch_target_o;
    imm_next = immediate_value_o;
    busy_next = busy_o;
    // done and illegal are one-cycle pulses
    done_next = 1'b0;
    illegal_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        // only a fresh request is taken
        if (req_i && !done_pend_reg) begin
          if (op_i != `OP_BRANCH) begin
            // immediates need no memory, so they answer at once
            imm_next = im_word;
            done_next = 1'b1;
            done_pend_next = 1'b1;
          end else if (!tag[`TAG_INDIR_BIT]) begin
            // direct target is always memory, even at 2F or below
            target_next = br_sum;
            done_next = 1'b1;
            done_pend_next = 1'b1;
          end else begin
            // indirect: fetch from memory regardless of base
            mem_addr_next = br_sum;
            mem_req_next = 1'b1;
            busy_next = 1'b1;
            state_next = S_WAIT;
          end
        end else if (!req_i) begin
          // a request still held after done is ignored until dropped
          done_pend_next = 1'b0;
        end
      end
      S_WAIT: begin
        // an ack outside this state is ignored
        if (mem_ack_i) begin
          mem_req_next = 1'b0;
          if (iw_zero != 4'h0) begin
            // bad chain word: no target, report illegal op
            illegal_next = 1'b1;
            done_next = 1'b1;
            busy_next = 1'b0;
            done_pend_next = 1'b1;
            state_next = S_IDLE;
          end else if (iw_more) begin
            // further level: its own index already added
            mem_addr_next = chain_sum;
            state_next = S_FETCH;
          end else begin
            // last level: its indexed address is the target
            target_next = chain_sum;
            done_next = 1'b1;
            busy_next = 1'b0;
            done_pend_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_FETCH: begin
        // one idle cycle between chained fetches lets memory drop ack
        mem_req_next = 1'b1;
        state_next = S_WAIT;
      end
      default: begin
        state_next = S_IDLE;
        mem_req_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  // state and outputs; every output comes straight from a flip-flop
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // reset: idle, no fetch pending, no pulses
      state_reg <= S_IDLE;
      done_pend_reg <= 1'b0;
      mem_req_o <= 1'b0;
      mem_addr_o <= 24'h000000;
      branch_target_o <= 24'h000000;
      immediate_value_o <= 32'h00000000;
      done_o <= 1'b0;
      illegal_op_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      // everything moves to its next value together
      state_reg <= state_next;
      done_pend_reg <= done_pend_next;
      mem_req_o <= mem_req_next;
      mem_addr_o <= mem_addr_next;
      branch_target_o <= target_next;
      immediate_value_o <= imm_next;
      done_o <= done_next;
      illegal_op_o <= illegal_next;
      busy_o <= busy_next;
    end
  end
endmodule

// ==== bench/index_unit_props_properties.sv ====
/* port checker for the branch and immediate index unit.
   assumes a bind onto the unit: one clock, async active-low reset. */
`timescale 1ns/1ps
module index_unit_props #(
  parameter AW = 24,
  parameter WW = 32
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire req_i,
  input wire [1:0] op_i,
  input wire [WW-1:0] instr_i,
  input wire [AW-1:0] instruction_address_counter_i,
  input wire [WW-1:0] mem_data_i,
  input wire mem_ack_i,
  input wire mem_req_o,
  input wire [AW-1:0] mem_addr_o,
  input wire [AW-1:0] branch_target_o,
  input wire [WW-1:0] immediate_value_o,
  input wire done_o,
  input wire illegal_op_o,
  input wire busy_o
);
  wire [23:0] word_addr = mem_data_i[23:0];
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // a request counts on its rise only, so a held request is not seen twice
  a_rel_target: assert property (
    $rose(req_i) && op_i == 2'h0 && instr_i[19:12] == 8'h0 |=> done_o &&
    branch_target_o == instruction_address_counter_i + {{12{instr_i[11]}}, instr_i[11:0]})
    else $error("counter relative target wrong");
  a_indirect_fetch: assert property (
    $rose(req_i) && op_i == 2'h0 && instr_i[19] |=> mem_req_o && busy_o && !done_o)
    else $error("indirect branch did not fetch");
  a_fetch_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch dropped or moved");
  a_bad_word: assert property (
    mem_req_o && mem_ack_i && mem_data_i[31:28] != 4'h0 |=> done_o && illegal_op_o)
    else $error("bad indirect word not flagged");
  a_last_word: assert property (
    mem_req_o && mem_ack_i && mem_data_i[31:27] == 5'h0 |=> done_o && !illegal_op_o && !busy_o)
    else $error("last indirect word not finished");
  a_more_word: assert property (
    mem_req_o && mem_ack_i && mem_data_i[31:24] == 8'h08 |=>
    !done_o ##1 mem_req_o && mem_addr_o == $past(word_addr, 2))
    else $error("chain level not fetched");
  a_imm_direct: assert property (
    $rose(req_i) && op_i != 2'h0 |=> done_o && !mem_req_o)
    else $error("immediate not answered directly");
  a_arith_plain: assert property (
    $rose(req_i) && op_i == 2'h2 && instr_i[19:16] == 4'h0 |=>
    immediate_value_o == {{16{instr_i[15]}}, instr_i[15:0]})
    else $error("arith immediate not sign extended");
  a_arith_top: assert property (
    done_o && op_i == 2'h2 |-> immediate_value_o[31:24] == {8{immediate_value_o[23]}})
    else $error("arith top byte not sum sign");
  a_logic_top: assert property (
    done_o && op_i == 2'h3 |-> immediate_value_o[31:24] == 8'h0)
    else $error("logical top byte not zero");
endmodule

bind branch_and_immediate_index_unit index_unit_props #(.AW(AW), .WW(WW)) u_props (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req_i), .op_i(op_i), .instr_i(instr_i),
  .instruction_address_counter_i(instruction_address_counter_i), .mem_data_i(mem_data_i),
  .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
  .branch_target_o(branch_target_o), .immediate_value_o(immediate_value_o),
  .done_o(done_o), .illegal_op_o(illegal_op_o), .busy_o(busy_o));

// ==== bench/mem_model.sv ====
/* memory partner answering indirect word fetches lat_i+1 cycles after the request rises.
   assumes one fetch at a time, held until acknowledged. */
`timescale 1ns/1ps
module mem_model (
  input wire clk_i,
  input wire rstn_i,
  input wire req_i,
  input wire [23:0] addr_i,
  input wire [3:0] lat_i,
  output logic ack_o,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:3];
  logic [3:0] cnt;
  // four words only: address bits 9:8 pick one
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      data_o <= 32'h0;
    end else if (req_i && !ack_o && cnt == lat_i) begin
      ack_o <= 1'b1;
      cnt <= 4'h0;
      data_o <= mem[addr_i[9:8]];
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o; // stale word is inverted each cycle, so it matches the acked word again every second cycle
      if (req_i && !ack_o) cnt <= cnt + 4'h1;
    end
  end
endmodule

// ==== bench/tb_branch_and_immediate_index_unit.sv ====
/* testbench: branch targets, immediates and indirect chains.
   assumes the memory partner model and the unit's checker bind. */
`timescale 1ns/1ps
module tb_branch_and_immediate_index_unit;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic [1:0] op = 2'h0;
  logic [31:0] ins = 32'h0;
  logic [23:0] iac = 24'h001000;
  logic [255:0] xr = {64'h0, 32'h40, 32'h0, 32'h12fffff0, 96'h0};
  logic [511:0] br = {416'h0, 32'hab000100, 64'h0};
  logic [3:0] lat = 4'h3;
  wire [31:0] md;
  wire ma;
  wire mq;
  wire [23:0] mad;
  wire [23:0] tgt;
  wire [31:0] imm;
  wire done;
  wire ill;
  wire busy;
  integer miscompares = 0;
  integer n_tests = 0;
  integer t = 0;
  always #10 clk = ~clk;
  branch_and_immediate_index_unit u_dut (.sys_clk_i(clk), .rstn_i(rstn), .req_i(req),
    .op_i(op), .instr_i(ins), .instruction_address_counter_i(iac), .index_regs_i(xr),
    .base_regs_i(br), .mem_data_i(md), .mem_ack_i(ma), .mem_req_o(mq), .mem_addr_o(mad),
    .branch_target_o(tgt), .immediate_value_o(imm), .done_o(done), .illegal_op_o(ill),
    .busy_o(busy));
  mem_model u_mem (.clk_i(clk), .rstn_i(rstn), .req_i(mq), .addr_i(mad), .lat_i(lat),
    .ack_o(ma), .data_o(md));
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("FAIL %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  // one request held until done; first fetch address checked on the way
  task run(input [1:0] o, input [31:0] i, input [31:0] e, input [23:0] ea, input l);
    integer n;
    reg seen;
    begin
      @(posedge clk);
      op <= o;
      ins <= i;
      req <= 1'b1;
      n = 0;
      seen = 1'b0;
      @(posedge clk);
      #1;
      while (done !== 1'b1 && n < 40) begin
        if (mq === 1'b1 && !seen) begin
          seen = 1'b1;
          chk({8'h0, mad}, {8'h0, ea});
          chk({31'h0, busy}, 32'h1);
        end
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk({31'h0, done}, 32'h1);
      chk({31'h0, ill}, {31'h0, l});
      chk({31'h0, busy}, 32'h0);
      if (!l) chk(o == 2'h0 ? {8'h0, tgt} : imm, e);
      @(posedge clk);
      req <= 1'b0;
      $display("test %0d end", t);
      t = t + 1;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // tests need under a hundred cycles; a hang ends long before the run limit
  initial begin
    #40000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  initial begin
    u_mem.mem[0] = 32'h05000200;
    u_mem.mem[1] = 32'h08000300;
    u_mem.mem[2] = 32'h50000000;
    u_mem.mem[3] = 32'h03000400;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    run(2'h0, 32'h00050ff0, 32'h001030, 24'h0, 1'b0);
    run(2'h0, 32'h00000800, 32'h000800, 24'h0, 1'b0);
    run(2'h0, 32'h00052ff0, 32'h001130, 24'h0, 1'b0);
    run(2'h0, 32'h00030001, 32'h000ff1, 24'h0, 1'b0);
    run(2'h1, 32'h00008000, 32'h00008000, 24'h0, 1'b0);
    run(2'h1, 32'h00038300, 32'h000082f0, 24'h0, 1'b0);
    run(2'h2, 32'h00009000, 32'hffff9000, 24'h0, 1'b0);
    run(2'h2, 32'h00038300, 32'hffff82f0, 24'h0, 1'b0);
    run(2'h2, 32'h00057500, 32'h00007540, 24'h0, 1'b0);
    run(2'h3, 32'h00009000, 32'h00009000, 24'h0, 1'b0);
    run(2'h3, 32'h00038300, 32'h000082f0, 24'h0, 1'b0);
    iac <= 24'h000010;
    run(2'h0, 32'h00080010, 32'h000240, 24'h000020, 1'b0);
    lat <= 4'h0;
    run(2'h0, 32'h000d2000, 32'h0003f0, 24'h000140, 1'b0);
    run(2'h0, 32'h00082100, 32'h0, 24'h000200, 1'b1);
    print_verdict;
  end
endmodule
